// ===== include/mcc_defines.svh
// constants for the mapper common control register pair
// assumes an 8-bit processor port with a 12-bit byte address
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define MCC_ADDR_W 12
`define MCC_OFS_FMT 12'h010
`define MCC_OFS_TIM 12'h011
`define MCC_RST_FMT 8'h30
`define MCC_RST_TIM 8'h00
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MCC_FMT_HI 7
`define MCC_FMT_LO 6
`define MCC_A_TRI 5
`define MCC_B_TRI 4
`define MCC_BIP_BLK 3
`define MCC_NPI_1 2
`define MCC_NPI_2 1
`define MCC_NPI_3 0
`define MCC_SW_TIM 7
`define MCC_DROP_TIM 6
`define MCC_ADD_DLY 5
`define MCC_LAT_EN 4
`define MCC_TX_AIS 3
`define MCC_CLK_INV 2
// ---------------------------------------------------------------
// null pointer indicator bytes
// ---------------------------------------------------------------
`define MCC_NPI_B0 8'h93
`define MCC_NPI_B1 8'he0
`define MCC_NPI_B2 8'h00
`endif

// ===== include/mcc_pkg.sv
// types for the mapper common control block
// assumes mcc_defines.svh sits on the include path
package mcc_pkg;
  // frame structure selected by the two format bits
  typedef enum logic [1:0] {
    MCC_STS1,
    MCC_STS3,
    MCC_STM1_AU3,
    MCC_STM1_TUG3
  } mcc_format_t;
  // timing reference for add data
  typedef enum logic {
    MCC_ADD_TIMING,
    MCC_DROP_TIMING
  } mcc_timing_t;
endpackage

// ===== rtl/mcc_delay_line.sv
// optional extra cycle of delay for the add bus data
// assumes caller supplies clock enable and reset
`timescale 1ns/10ps
`include "mcc_defines.svh"
module mcc_delay_line #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic two_cycle,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1; // the optional extra cycle of lag
  initial begin
    if (WIDTH < 1) begin
      $error("width must be positive");
    end
  end
  // ---------------------------------------------------------------
  // pipeline
  // ---------------------------------------------------------------
  // the caller's output register gives the first cycle of lag,
  // so this stage only adds the second one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
    end else if (clk_en) begin
      stage1 <= din;
    end
  end
  // switching the lag mid-stream repeats or drops one byte
  always_comb begin
    dout = two_cycle ? stage1 : din;
  end
endmodule

// ===== rtl/mcc_edge_latch.sv
// one latched event bit with level or transition latching
// assumes alarm input is synchronous to core_clk
`timescale 1ns/10ps
module mcc_edge_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic trans_en,
  input wire logic rise_sel,
  input wire logic fall_sel,
  input wire logic clr,
  // alarm
  input wire logic alarm,
  output logic event_bit
);
  logic alarm_d; // previous alarm level
  logic set_ev; // latch condition this cycle
  // ---------------------------------------------------------------
  // set condition
  // ---------------------------------------------------------------
  always_comb begin
    if (trans_en) begin
      set_ev = (rise_sel && alarm && !alarm_d) ||
               (fall_sel && !alarm && alarm_d);
    end else begin
      set_ev = alarm; // selects ignored here
    end
  end
  // ---------------------------------------------------------------
  // sticky bit
  // ---------------------------------------------------------------
  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_d <= 1'b0;
      event_bit <= 1'b0;
    end else if (clk_en) begin
      alarm_d <= alarm;
      if (set_ev) begin
        event_bit <= 1'b1;
      end else if (clr) begin
        event_bit <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/mcc_common_ctrl.sv
// common control registers of one four-port e1 mapper group
// assumes a synchronous 8-bit processor port on core_clk (50 MHz)
`timescale 1ns/10ps
`include "mcc_defines.svh"
module mcc_common_ctrl #(
  parameter int PORTS = 4,
  parameter int ALARMS = 4,
  parameter int DW = 8
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // processor port
  input wire logic cpu_sel,
  input wire logic cpu_wr,
  input wire logic [`MCC_ADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_hit,
  // soft reset and hardware lead
  input wire logic soft_rst,
  input wire logic hw_timing_sel_lead,
  // transmit clock health per timing source
  input wire logic add_tx_clk_lost,
  input wire logic drop_tx_clk_lost,
  // add bus data before output stage
  input wire logic [DW-1:0] add_timed_data,
  input wire logic [DW-1:0] drop_timed_data,
  input wire logic npi_slot,
  input wire logic [1:0] npi_byte_idx,
  input wire logic [1:0] npi_tug3,
  // add bus pins, side a and b
  output logic [DW-1:0] side_a_add_data,
  output logic side_a_add_oe,
  output logic [DW-1:0] side_b_add_data,
  output logic side_b_add_oe,
  // bip-2 error report
  input wire logic [1:0] bip2_err_cnt,
  output logic bip2_count_inc,
  output logic [1:0] bip2_count_step,
  // e1 transmit side
  input wire logic [PORTS-1:0] e1_los,
  input wire logic [PORTS-1:0] e1_loc,
  input wire logic [PORTS-1:0] e1_tx_data,
  output logic [PORTS-1:0] e1_tx_ais,
  output logic [PORTS-1:0] e1_tx_data_out,
  output logic tx_sample_rising,
  // alarm latching
  input wire logic [ALARMS-1:0] alarm_in,
  input wire logic rising_transition_sel,
  input wire logic falling_transition_sel,
  input wire logic [ALARMS-1:0] alarm_clr,
  output logic [ALARMS-1:0] alarm_event,
  // decoded settings
  output mcc_pkg::mcc_format_t frame_format,
  output mcc_pkg::mcc_timing_t timing_mode
);
  import mcc_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] fmt_reg; // format and add output control
  logic [7:0] tim_reg; // bus timing and line control
  logic any_rst; // soft reset folded in synchronously
  logic wr_fmt; // write strobe for first register
  logic wr_tim; // write strobe for second register
  logic drop_sel; // chosen timing reference
  logic clk_lost; // chosen transmit clock missing
  logic [DW-1:0] ref_data; // data on chosen reference
  logic [DW-1:0] lagged; // delayed add data
  logic [DW-1:0] npi_byte; // null pointer byte to send
  logic npi_on; // this tug-3 has npi enabled
  logic [PORTS-1:0] tx_rise_q; // data sampled on rise
  logic [PORTS-1:0] tx_fall_q; // data sampled on fall

  // byte lanes and pointer bytes are fixed at eight bits
  initial begin
    if (PORTS < 1 || ALARMS < 1 || DW != 8) begin
      $error("unsupported parameter values");
    end
  end

  // address match used by both reads and writes
  // one function keeps read and write decode from drifting apart
  function automatic logic addr_is(input logic [`MCC_ADDR_W-1:0] a,
                                   input logic [`MCC_ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign any_rst = soft_rst;
  assign wr_fmt = cpu_sel && cpu_wr && addr_is(cpu_addr, `MCC_OFS_FMT);
  assign wr_tim = cpu_sel && cpu_wr && addr_is(cpu_addr, `MCC_OFS_TIM);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // soft reset restores the same values as the pin reset
  // both add buses come up floating, so nothing collides on a shared
  // telecom bus before software has picked the format
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fmt_reg <= `MCC_RST_FMT;
    end else if (clk_en) begin
      if (any_rst) begin
        fmt_reg <= `MCC_RST_FMT;
      end else if (wr_fmt) begin
        fmt_reg <= cpu_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tim_reg <= `MCC_RST_TIM;
    end else if (clk_en) begin
      if (any_rst) begin
        tim_reg <= `MCC_RST_TIM;
      end else if (wr_tim) begin
        tim_reg <= cpu_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // read data registered; unmapped offsets read zero with no hit
  // bits 1:0 of the timing register belong to other logic and read zero
  // a read has no side effect, so polling is harmless
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
      cpu_hit <= 1'b0;
    end else if (clk_en) begin
      cpu_hit <= cpu_sel && !cpu_wr &&
                 (addr_is(cpu_addr, `MCC_OFS_FMT) || addr_is(cpu_addr, `MCC_OFS_TIM));
      if (cpu_sel && !cpu_wr && addr_is(cpu_addr, `MCC_OFS_FMT)) begin
        cpu_rdata <= fmt_reg;
      end else if (cpu_sel && !cpu_wr && addr_is(cpu_addr, `MCC_OFS_TIM)) begin
        cpu_rdata <= {tim_reg[7:2], 2'b00};
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // format and timing decode
  // ---------------------------------------------------------------
  assign frame_format = mcc_format_t'({fmt_reg[`MCC_FMT_HI], fmt_reg[`MCC_FMT_LO]});

  // hardware lead rules until software takes over
  // the lead is taken as a level on core_clk, not resynchronised
  always_comb begin
    if (tim_reg[`MCC_SW_TIM]) begin
      drop_sel = tim_reg[`MCC_DROP_TIM];
    end else begin
      drop_sel = hw_timing_sel_lead;
    end
  end
  assign timing_mode = drop_sel ? MCC_DROP_TIMING : MCC_ADD_TIMING;
  assign ref_data = drop_sel ? drop_timed_data : add_timed_data;
  // clock loss picks its source from the drop bit alone, even while the
  // lead chooses timing; a stale drop bit can hide a real loss
  assign clk_lost = tim_reg[`MCC_DROP_TIM] ? drop_tx_clk_lost : add_tx_clk_lost;

  // ---------------------------------------------------------------
  // add data lag
  // ---------------------------------------------------------------
  // the output register below is the first cycle of lag; the delay
  // line only adds the optional second cycle
  mcc_delay_line #(
    .WIDTH(DW)
  ) u_lag (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .two_cycle(tim_reg[`MCC_ADD_DLY]),
    .din(ref_data),
    .dout(lagged)
  );

  // ---------------------------------------------------------------
  // null pointer bytes
  // ---------------------------------------------------------------
  always_comb begin
    // index three is unused and falls back to the last byte
    case (npi_byte_idx)
      2'h0: npi_byte = `MCC_NPI_B0;
      2'h1: npi_byte = `MCC_NPI_B1;
      default: npi_byte = `MCC_NPI_B2;
    endcase
  end

  always_comb begin
    // tug-3 index three has no indicator bit and floats if marked
    case (npi_tug3)
      2'h0: npi_on = fmt_reg[`MCC_NPI_1];
      2'h1: npi_on = fmt_reg[`MCC_NPI_2];
      2'h2: npi_on = fmt_reg[`MCC_NPI_3];
      default: npi_on = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // add bus output stage
  // ---------------------------------------------------------------
  // data registered; enables combine register bits and clock health
  // enables stay combinational so a lost clock floats the bus at once
  // a pointer slot with its indicator clear floats in the same cycle
  logic npi_act; // pointer slot active in tug-3 mode
  assign npi_act = npi_slot && (frame_format == MCC_STM1_TUG3);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      side_a_add_data <= '0;
      side_b_add_data <= '0;
    end else if (clk_en) begin
      side_a_add_data <= (npi_act && npi_on) ? npi_byte : lagged;
      side_b_add_data <= (npi_act && npi_on) ? npi_byte : lagged;
    end
  end
  // processor must clear the disable bits to let traffic out
  assign side_a_add_oe = !fmt_reg[`MCC_A_TRI] && !clk_lost &&
                         !(npi_act && !npi_on);
  assign side_b_add_oe = !fmt_reg[`MCC_B_TRI] && !clk_lost &&
                         !(npi_act && !npi_on);

  // ---------------------------------------------------------------
  // bip-2 counting
  // ---------------------------------------------------------------
  // a block of two errors is one count when block mode is set
  // a three-error report is treated like any other non-zero count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bip2_count_inc <= 1'b0;
      bip2_count_step <= 2'b00;
    end else if (clk_en) begin
      bip2_count_inc <= (bip2_err_cnt != 2'b00);
      if (fmt_reg[`MCC_BIP_BLK] && bip2_err_cnt != 2'b00) begin
        bip2_count_step <= 2'b01;
      end else begin
        bip2_count_step <= bip2_err_cnt;
      end
    end
  end

  // ---------------------------------------------------------------
  // e1 transmit side
  // ---------------------------------------------------------------
  // the falling copy is taken on the negedge of the system clock
  // it trades half a cycle of setup for the choice of edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_rise_q <= '0;
    end else if (clk_en) begin
      tx_rise_q <= e1_tx_data;
    end
  end
  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      tx_fall_q <= '0;
    end else if (clk_en) begin
      tx_fall_q <= e1_tx_data;
    end
  end
  assign tx_sample_rising = tim_reg[`MCC_CLK_INV];

  // one output flop pair per port; ais overrides the sampled data
  // so the far side sees a clean all-ones stream
  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_port
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          e1_tx_ais[gi] <= 1'b0;
          e1_tx_data_out[gi] <= 1'b0;
        end else if (clk_en) begin
          e1_tx_ais[gi] <= tim_reg[`MCC_TX_AIS] && (e1_los[gi] || e1_loc[gi]);
          if (tim_reg[`MCC_TX_AIS] && (e1_los[gi] || e1_loc[gi])) begin
            e1_tx_data_out[gi] <= 1'b1;
          end else begin
            e1_tx_data_out[gi] <= tim_reg[`MCC_CLK_INV] ? tx_rise_q[gi]
                                                        : tx_fall_q[gi];
          end
        end
      end
    end
    // one latch per alarm; the transition selects are shared by all
    for (gi = 0; gi < ALARMS; gi++) begin : g_alarm
      mcc_edge_latch u_latch (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .trans_en(tim_reg[`MCC_LAT_EN]),
        .rise_sel(rising_transition_sel),
        .fall_sel(falling_transition_sel),
        .clr(alarm_clr[gi]),
        .alarm(alarm_in[gi]),
        .event_bit(alarm_event[gi])
      );
    end
  endgenerate
endmodule

// ===== test/mcc_ctrl_props.sv
// concurrent checks on the common control ports
// assumes bind from tb_top and clk_en held high by the bench
`timescale 1ns/10ps
`include "mcc_defines.svh"
module mcc_ctrl_props
  import mcc_pkg::*;
#(
  parameter int PORTS = 4
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // processor port
  input wire logic cpu_sel,
  input wire logic cpu_wr,
  input wire logic [`MCC_ADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_hit,
  // timing and add bus
  input wire logic hw_timing_sel_lead,
  input wire logic add_tx_clk_lost,
  input wire logic drop_tx_clk_lost,
  input wire logic npi_slot,
  input wire logic [1:0] npi_tug3,
  input wire logic side_a_add_oe,
  input wire logic side_b_add_oe,
  // counters and e1 side
  input wire logic [1:0] bip2_err_cnt,
  input wire logic bip2_count_inc,
  input wire logic [1:0] bip2_count_step,
  input wire logic [PORTS-1:0] e1_los,
  input wire logic [PORTS-1:0] e1_loc,
  input wire logic [PORTS-1:0] e1_tx_ais,
  // decoded settings
  input wire mcc_pkg::mcc_format_t frame_format,
  input wire mcc_pkg::mcc_timing_t timing_mode
);
  // ------------------------------------------------
  // register shadow
  // ------------------------------------------------
  logic [7:0] fmt_q; // expected format register
  logic [7:0] tim_q; // expected timing register
  wire rd_go = cpu_sel && !cpu_wr;
  wire wr_fmt = cpu_sel && cpu_wr && cpu_addr == `MCC_OFS_FMT;
  wire wr_tim = cpu_sel && cpu_wr && cpu_addr == `MCC_OFS_TIM;
  // soft reset reloads the pair's reset values just like the hard one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fmt_q <= `MCC_RST_FMT;
    end else if (soft_rst || wr_fmt) begin
      fmt_q <= soft_rst ? `MCC_RST_FMT : cpu_wdata;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tim_q <= `MCC_RST_TIM;
    end else if (soft_rst || wr_tim) begin
      tim_q <= soft_rst ? `MCC_RST_TIM : cpu_wdata;
    end
  end
  // expected values worked out from the shadow
  wire lost = tim_q[6] ? drop_tx_clk_lost : add_tx_clk_lost;
  wire exp_drop = tim_q[7] ? tim_q[6] : hw_timing_sel_lead;
  wire npi_on = npi_tug3 == 2'd0 ? fmt_q[2] : (npi_tug3 == 2'd1 ? fmt_q[1] : fmt_q[0]);
  wire [1:0] bip_exp = (fmt_q[3] && bip2_err_cnt == 2'd2) ? 2'd1 : bip2_err_cnt;
  wire [PORTS-1:0] ais_exp = tim_q[3] ? (e1_los | e1_loc) : '0;
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_fmt_read_back: assert property (rd_go && cpu_addr == `MCC_OFS_FMT |=>
    cpu_hit && cpu_rdata == $past(fmt_q)) else $error("format read wrong");
  a_unmapped_read: assert property (rd_go && cpu_addr > `MCC_OFS_TIM |=>
    !cpu_hit && cpu_rdata == 8'h00) else $error("unmapped read answered");
  a_oe_side_a: assert property (!npi_slot |-> side_a_add_oe == !(fmt_q[5] || lost))
    else $error("side a enable wrong");
  a_oe_side_b: assert property (!npi_slot |-> side_b_add_oe == !(fmt_q[4] || lost))
    else $error("side b enable wrong");
  a_format_decode: assert property (frame_format == mcc_format_t'(fmt_q[7:6]))
    else $error("format decode wrong");
  a_timing_source: assert property (timing_mode == mcc_timing_t'(exp_drop))
    else $error("timing source wrong");
  a_npi_float: assert property (npi_slot && fmt_q[7:6] == 2'b11 && !npi_on |->
    !side_a_add_oe && !side_b_add_oe) else $error("null pointer slot driven");
  a_bip_step: assert property (bip2_err_cnt != 2'd0 |=>
    bip2_count_inc && bip2_count_step == $past(bip_exp)) else $error("bip step wrong");
  a_tx_ais: assert property (1'b1 |=> e1_tx_ais == $past(ais_exp))
    else $error("tx ais wrong");
  cover property (npi_slot && fmt_q[7:6] == 2'b11 && npi_on);
  cover property (lost && !fmt_q[5]);
  cover property (|e1_tx_ais);
endmodule

// ===== test/mcc_bus_model.sv
// far side of the add bus: timed byte streams and the side a wire
// assumes one clock domain; the add wire has no pull resistor
`timescale 1ns/10ps
module mcc_bus_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // add bus from the block
  input wire logic [7:0] side_a_add_data,
  input wire logic side_a_add_oe,
  // streams and resolved wire
  output logic [7:0] add_timed_data,
  output logic [7:0] drop_timed_data,
  output logic [7:0] bus_a
);
  logic [7:0] last_a; // last value seen driven
  // streams differ every cycle so a wrong lag or source shows
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      add_timed_data <= 8'h11;
      drop_timed_data <= 8'h80;
    end else begin
      add_timed_data <= add_timed_data + 8'h03;
      drop_timed_data <= drop_timed_data - 8'h05;
    end
  end
  // a floating wire shows the inverse, never a lucky match
  always_ff @(posedge core_clk) begin
    if (side_a_add_oe) begin
      last_a <= side_a_add_data;
    end
  end
  assign bus_a = side_a_add_oe ? side_a_add_data : ~last_a;
endmodule

// ===== test/tb_top.sv
// self-checking bench for the common control register pair
// assumes design files, mcc_bus_model and mcc_ctrl_props compiled first
`timescale 1ns/10ps
`include "mcc_defines.svh"
module tb_top;
  import mcc_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic core_clk = 0, rst = 1, clk_en = 1, cpu_sel = 0, cpu_wr = 0, soft_rst = 0;
  logic hw_timing_sel_lead = 0, add_tx_clk_lost = 0, drop_tx_clk_lost = 0, npi_slot = 0;
  logic rising_transition_sel = 0, falling_transition_sel = 0, cpu_hit;
  logic side_a_add_oe, side_b_add_oe, bip2_count_inc, tx_sample_rising;
  logic [`MCC_ADDR_W-1:0] cpu_addr = 0;
  logic [7:0] cpu_wdata = 0, cpu_rdata, add_timed_data, drop_timed_data;
  logic [7:0] side_a_add_data, side_b_add_data, bus_a;
  logic [1:0] npi_byte_idx = 0, npi_tug3 = 0, bip2_err_cnt = 0, bip2_count_step;
  logic [3:0] e1_los = 0, e1_loc = 0, e1_tx_data = 0, e1_tx_ais, e1_tx_data_out;
  logic [3:0] alarm_in = 0, alarm_clr = 0, alarm_event;
  mcc_format_t frame_format;
  mcc_timing_t timing_mode;
  int n_fail = 0, checked = 0;
  always #10 core_clk = ~core_clk;
  mcc_common_ctrl mcc_common_ctrl_inst (.*);
  mcc_bus_model mcc_bus_model_inst (.*);
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {cpu_sel, cpu_wr, cpu_addr, cpu_wdata} <= {2'b11, a, d};
    @(posedge core_clk);
    {cpu_sel, cpu_wr} <= 2'b00;
    #1;
  endtask
  // read answers one edge after the request is taken
  task rd(input logic [11:0] a, input logic [7:0] exp, input logic hit);
    @(posedge core_clk);
    {cpu_sel, cpu_addr} <= {1'b1, a};
    @(posedge core_clk);
    cpu_sel <= 1'b0;
    #1;
    chk(cpu_rdata, exp);
    chk(8'(cpu_hit), 8'(hit));
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task t_reset();
    chk(8'({side_a_add_oe, side_b_add_oe}), 8'h00);
    rd(`MCC_OFS_FMT, 8'h30, 1'b1);
    rd(`MCC_OFS_TIM, 8'h00, 1'b1);
    rd(12'h012, 8'h00, 1'b0);
    for (int f = 0; f < 4; f++) begin
      wr(`MCC_OFS_FMT, {f[1:0], 6'h3a});
      chk(8'(frame_format), 8'(f));
      rd(`MCC_OFS_FMT, {f[1:0], 6'h3a}, 1'b1);
    end
    wr(`MCC_OFS_TIM, 8'hff);
    rd(`MCC_OFS_TIM, 8'hfc, 1'b1);
    wr(`MCC_OFS_FMT, 8'h00);
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    rd(`MCC_OFS_FMT, 8'h30, 1'b1);
  endtask
  task t_oe();
    for (int i = 0; i < 4; i++) begin
      wr(`MCC_OFS_FMT, {2'b00, i[1:0], 4'h0});
      chk(8'({side_a_add_oe, side_b_add_oe}), {6'h00, ~i[1:0]});
    end
    wr(`MCC_OFS_TIM, 8'h00);
    wr(`MCC_OFS_FMT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {add_tx_clk_lost, drop_tx_clk_lost} <= 2'b10;
      wr(`MCC_OFS_TIM, {1'b0, i[0], 6'h00});
      chk(8'(side_a_add_oe), 8'(i[0]));
      @(posedge core_clk);
      {add_tx_clk_lost, drop_tx_clk_lost} <= 2'b01;
      #1;
      chk(8'(side_b_add_oe), 8'(!i[0]));
    end
    @(posedge core_clk);
    drop_tx_clk_lost <= 1'b0;
  endtask
  task t_timing();
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      hw_timing_sel_lead <= i[0];
      wr(`MCC_OFS_TIM, {i[2:1], 6'h00});
      chk(8'(timing_mode), 8'(i[2] ? i[1] : i[0]));
    end
    for (int d = 0; d < 4; d++) begin
      @(posedge core_clk);
      hw_timing_sel_lead <= d[1];
      wr(`MCC_OFS_TIM, {2'b00, d[0], 5'h00});
      @(posedge core_clk);
      #1;
      r = d[1] ? drop_timed_data : add_timed_data;
      repeat (1 + d[0]) @(posedge core_clk);
      #1;
      chk(side_a_add_data, r);
      chk(bus_a, r);
    end
  endtask
  task t_npi();
    logic [7:0] npb [3] = '{`MCC_NPI_B0, `MCC_NPI_B1, `MCC_NPI_B2};
    wr(`MCC_OFS_FMT, 8'hc5);
    for (int k = 0; k < 9; k++) begin
      @(posedge core_clk);
      {npi_slot, npi_tug3, npi_byte_idx} <= {1'b1, 2'(k / 3), 2'(k % 3)};
      #1;
      chk(8'(side_a_add_oe), 8'(k / 3 != 1));
      @(posedge core_clk);
      npi_slot <= 1'b0;
      #1;
      if (k / 3 != 1) chk(side_a_add_data, npb[k % 3]);
    end
  endtask
  task t_misc();
    for (int i = 0; i < 4; i++) begin
      wr(`MCC_OFS_FMT, {4'h0, i[1], 3'h0});
      @(posedge core_clk);
      bip2_err_cnt <= i[0] ? 2'd2 : 2'd1;
      @(posedge core_clk);
      bip2_err_cnt <= 2'd0;
      #1;
      chk(8'({bip2_count_inc, bip2_count_step}), {5'h00, 1'b1, i == 1 ? 2'd2 : 2'd1});
    end
    wr(`MCC_OFS_TIM, 8'h0c);
    @(posedge core_clk);
    {e1_los, e1_loc, e1_tx_data} <= {4'h2, 4'h4, 4'h5};
    @(posedge core_clk);
    #1;
    chk(8'(e1_tx_ais), 8'h06);
    chk(8'(tx_sample_rising), 8'h01);
    @(posedge core_clk);
    #1;
    chk(8'(e1_tx_data_out), 8'h07);
    wr(`MCC_OFS_TIM, 8'h00);
    @(posedge core_clk);
    e1_tx_data <= 4'ha;
    @(posedge core_clk);
    #1;
    chk(8'({e1_tx_ais, tx_sample_rising}), 8'h00);
    chk(8'(e1_tx_data_out), 8'h0a);
    @(posedge core_clk);
    alarm_in <= 4'h1;
    @(posedge core_clk);
    alarm_in <= 4'h0;
    #1;
    chk(8'(alarm_event), 8'h01);
    wr(`MCC_OFS_TIM, 8'h10);
    @(posedge core_clk);
    alarm_clr <= 4'h1;
    @(posedge core_clk);
    {alarm_in, alarm_clr} <= {4'h1, 4'h0};
    repeat (2) @(posedge core_clk);
    #1;
    chk(8'(alarm_event), 8'h00);
    @(posedge core_clk);
    {rising_transition_sel, alarm_in} <= {1'b1, 4'h0};
    @(posedge core_clk);
    alarm_in <= 4'h1;
    @(posedge core_clk);
    #1;
    chk(8'(alarm_event), 8'h01);
    @(posedge core_clk);
    {rising_transition_sel, falling_transition_sel, alarm_clr} <= {1'b0, 1'b1, 4'h1};
    @(posedge core_clk);
    {alarm_in, alarm_clr} <= {4'h0, 4'h0};
    #1;
    chk(8'(alarm_event), 8'h00);
    @(posedge core_clk);
    #1;
    chk(8'(alarm_event), 8'h01);
  endtask
  // ------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------
  task wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    $display("test t_reset done");
    t_oe();
    $display("test t_oe done");
    t_timing();
    $display("test t_timing done");
    t_npi();
    $display("test t_npi done");
    t_misc();
    $display("test t_misc done");
    wrap_up();
  end
  // watchdog: scenarios need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule
bind mcc_common_ctrl mcc_ctrl_props #(.PORTS(PORTS)) mcc_ctrl_props_inst (.*);
